// ### pkg/fpl_pkg.sv
// shared constants, types and helpers of the fast parallel loader
package fpl_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned POR_DELAY_US = 100;
  localparam int unsigned POR_CYCLES = POR_DELAY_US * CLK_MHZ;
  localparam int unsigned IMAGE_WORDS = 8192;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned SYNC_W = 36;
  localparam int unsigned BUF_DEPTH = 2;
  localparam logic [1:0] INIT_EDGES = 2'h2;
  localparam logic [3:0] RATIO_ONE = 4'h1;
  localparam logic [3:0] RATIO_TWO = 4'h2;
  localparam logic [3:0] RATIO_FOUR = 4'h4;
  localparam logic [3:0] RATIO_EIGHT = 4'h8;

  typedef enum logic [1:0] {W8, W16, W32} fpl_width_e;
  typedef enum logic [2:0] {
    ST_POR, ST_HOLD, ST_LOAD, ST_INIT, ST_USER, ST_FAULT
  } fpl_state_e;

  // clock edges per data word for bus width and image options
  function automatic logic [3:0] fpl_ratio(fpl_width_e w, logic dc,
                                           logic sec);
    logic [3:0] r;
    r = RATIO_ONE;
    case (w)
      W8: begin
        if (dc) r = RATIO_TWO;
      end
      W16: begin
        if (dc) r = RATIO_FOUR;
        else if (sec) r = RATIO_TWO;
      end
      default: begin
        if (dc) r = RATIO_EIGHT;
        else if (sec) r = RATIO_FOUR;
      end
    endcase
    return r;
  endfunction
endpackage

// ### pkg/fpl_buf_if.sv
// valid/ready word channel between loader and its buffer
`timescale 1ns/100ps
`default_nettype none
interface fpl_buf_if;
  logic valid;
  logic ready;
  logic [31:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### logic/fpl_buffer.sv
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module fpl_buffer (
  input wire logic clk,
  input wire logic resetn,
  fpl_buf_if.snk fill,
  fpl_buf_if.src drain
);
  import fpl_pkg::*;

  logic [31:0] mem [BUF_DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  assign fill.ready = (count != 2'h2);
  assign drain.valid = (count != 2'h0);
  assign drain.data = mem[rd_ptr];
  assign push = fill.valid && fill.ready;
  assign pop = drain.valid && drain.ready;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      if (push && !pop) count <= count + 2'h1;
      else if (pop && !push) count <= count - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem[0] <= 32'h0;
      mem[1] <= 32'h0;
    end else if (push) begin
      mem[wr_ptr] <= fill.data;
    end
  end
endmodule
`default_nettype wire

// ### logic/fpl_loader.sv
// fast parallel configuration loader, device side
`timescale 1ns/100ps
`default_nettype none
// How it works
// - ratio from width and options: 1, 2, 4 or 8 edges per word
// - request pin low at any time after the power-on delay aborts and restarts configuration
// - in user operation request, health and load-complete pins are high
// - health pin held low through the power-on delay
// - load-complete low from power-up until every word has arrived
// - after configuration the configuration clock is ignored
// - load-complete released only after the whole image arrived cleanly
// - with the option set, init-done pin low until initialization ends
module fpl_loader #(
  parameter int unsigned POR_CNT = fpl_pkg::POR_CYCLES,
  parameter int unsigned IMAGE_LEN = fpl_pkg::IMAGE_WORDS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic config_request_n,
  input wire logic config_clock,
  input wire logic [31:0] config_data,
  input wire fpl_pkg::fpl_width_e bus_width,
  input wire logic decompress_en,
  input wire logic security_en,
  input wire logic init_done_opt,
  input wire logic config_health_n_in,
  output logic config_health_n_out,
  output logic config_health_n_oe_n,
  input wire logic load_complete_in,
  output logic load_complete_out,
  output logic load_complete_oe_n,
  input wire logic init_done_in,
  output logic init_done_out,
  output logic init_done_oe_n,
  output logic word_valid,
  input wire logic word_ready,
  output logic [31:0] word_data,
  output logic user_mode,
  output logic load_error
);
  import fpl_pkg::*;

  localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_CNT - 1);
  localparam logic [CNT_W-1:0] IMG_LEN = CNT_W'(IMAGE_LEN);

  fpl_buf_if fill_if ();
  fpl_buf_if drain_if ();

  fpl_state_e state;
  fpl_state_e next_state;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic clk_d;
  logic req_s;
  logic clk_s;
  logic done_s;
  logic [31:0] data_s;
  logic rise;
  logic fall;
  logic [CNT_W-1:0] por_cnt;
  logic [CNT_W-1:0] words;
  logic [3:0] ratio;
  logic [3:0] beat;
  fpl_width_e width_q;
  logic init_opt_q;
  logic [31:0] hold;
  logic [31:0] pend;
  logic pend_valid;
  logic word_end;
  logic overrun;
  logic load_done;
  logic [1:0] init_cnt;
  logic [31:0] data_m;

  // pins and the other domain pass two flip-flops first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= '0;
      sync2 <= '0;
      clk_d <= 1'b0;
    end else begin
      sync1 <= {init_done_in, load_complete_in, config_request_n,
                config_clock, config_data};
      sync2 <= sync1;
      clk_d <= clk_s;
    end
  end

  assign data_s = sync2[31:0];
  assign clk_s = sync2[32];
  assign req_s = sync2[33];
  assign done_s = sync2[34];
  assign rise = clk_s && !clk_d;
  assign fall = !clk_s && clk_d;

  assign word_end = (state == ST_LOAD) && rise && (beat == ratio - 4'h1);
  assign overrun = word_end && pend_valid && !fill_if.ready;
  // release waits until the last clock of the image has fallen
  assign load_done = (words == IMG_LEN) && !pend_valid && !word_valid &&
                     !clk_s;

  // narrow buses use only their low lanes
  always_comb begin
    case (width_q)
      W8: data_m = {24'h0, data_s[7:0]};
      W16: data_m = {16'h0, data_s[15:0]};
      default: data_m = data_s;
    endcase
  end

  // sequence of power-on, hold, load, initialization and user operation
  always_comb begin
    next_state = state;
    unique case (state)
      ST_POR: begin
        if (por_cnt == POR_LAST) next_state = ST_HOLD;
      end
      ST_HOLD: begin
        if (req_s) next_state = ST_LOAD;
      end
      ST_LOAD: begin
        if (overrun) next_state = ST_FAULT;
        else if (load_done) next_state = ST_INIT;
      end
      ST_INIT: begin
        if (done_s && fall && init_cnt == INIT_EDGES - 2'h1) begin
          next_state = ST_USER;
        end
      end
      default: begin
        next_state = state;
      end
    endcase
    if (!req_s && state != ST_POR) next_state = ST_HOLD;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) state <= ST_POR;
    else state <= next_state;
  end

  // power-on delay count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) por_cnt <= '0;
    else if (state == ST_POR) por_cnt <= por_cnt + CNT_W'(1);
  end

  // options are caught while waiting for the load to begin
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      width_q <= W8;
      ratio <= RATIO_ONE;
      init_opt_q <= 1'b0;
    end else if (state == ST_HOLD) begin
      width_q <= bus_width;
      ratio <= fpl_ratio(bus_width, decompress_en, security_en);
      init_opt_q <= init_done_opt;
    end
  end

  // edge counting per word; data taken at the group's first edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      beat <= 4'h0;
      hold <= 32'h0;
    end else if (state != ST_LOAD) begin
      beat <= 4'h0;
    end else if (rise) begin
      if (beat == 4'h0) hold <= data_m;
      if (word_end) beat <= 4'h0;
      else beat <= beat + 4'h1;
    end
  end

  // completed word waits here until the buffer takes it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend <= 32'h0;
      pend_valid <= 1'b0;
      words <= '0;
    end else if (state == ST_HOLD) begin
      pend_valid <= 1'b0;
      words <= '0;
    end else begin
      if (word_end && !overrun) begin
        pend <= (beat == 4'h0) ? data_m : hold;
        pend_valid <= 1'b1;
        words <= words + CNT_W'(1);
      end else if (pend_valid && fill_if.ready) begin
        pend_valid <= 1'b0;
      end
    end
  end

  // clock falls are counted only while load-complete is seen high
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) init_cnt <= 2'h0;
    else if (state != ST_INIT) init_cnt <= 2'h0;
    else if (done_s && fall) init_cnt <= init_cnt + 2'h1;
  end

  // pending word into the buffer, buffer out to the word stream
  assign fill_if.valid = pend_valid;
  assign fill_if.data = pend;
  assign drain_if.ready = word_ready;
  assign word_valid = drain_if.valid;
  assign word_data = drain_if.data;

  fpl_buffer u_buffer (
    .clk(clk),
    .resetn(resetn),
    .fill(fill_if),
    .drain(drain_if)
  );

  // open-drain pins pull low while enable is low
  assign config_health_n_out = 1'b0;
  assign load_complete_out = 1'b0;
  assign init_done_out = 1'b0;
  assign config_health_n_oe_n = (state == ST_LOAD) || (state == ST_INIT) ||
                                (state == ST_USER);
  assign load_complete_oe_n = (state == ST_INIT) ||
                              (state == ST_USER);
  assign init_done_oe_n = !(init_opt_q && state != ST_USER);
  assign user_mode = (state == ST_USER);
  assign load_error = (state == ST_FAULT);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_request_abort: assert property (
    (!req_s && state != ST_POR) |=> state == ST_HOLD)
    else $error("request low did not restart loading");
  a_user_pins_high: assert property (
    state == ST_USER |-> config_health_n_oe_n && load_complete_oe_n
    && init_done_oe_n && $past(req_s))
    else $error("pins not released in user operation");
  a_por_health: assert property (
    state == ST_POR |-> !config_health_n_oe_n
    && por_cnt <= POR_LAST)
    else $error("health pin released during power-on delay");
  a_done_low_load: assert property (
    state inside {ST_POR, ST_HOLD, ST_LOAD} |-> !load_complete_oe_n)
    else $error("load-complete released early");
  a_user_ignores_clk: assert property (
    (state == ST_USER && req_s) |=> state == ST_USER
    && $stable(words))
    else $error("clock activity changed user operation");
  a_word_ratio: assert property (
    (word_end && !overrun) |=> pend_valid
    && words == $past(words) + CNT_W'(1))
    else $error("word not formed at last edge of group");
  a_release_all: assert property (
    $rose(load_complete_oe_n) |-> $past(words) == IMG_LEN)
    else $error("load-complete released before full image");
  a_two_falls: assert property (
    (state == ST_INIT && req_s && done_s && fall
     && init_cnt == 2'h1) |=> state == ST_USER)
    else $error("two falling edges did not enter user operation");
  a_init_pin: assert property (
    (init_opt_q && state inside {ST_LOAD, ST_INIT}) |-> !init_done_oe_n)
    else $error("init-done released before initialization end");

  c_reach_user: cover property (state == ST_INIT ##[1:1000] state == ST_USER);
  c_overrun: cover property (state == ST_LOAD ##1 state == ST_FAULT);
  c_user_abort: cover property (state == ST_USER ##1 state == ST_HOLD);
  c_word_stall: cover property (pend_valid && !fill_if.ready);
endmodule
`default_nettype wire

// ### test/fpl_host.sv
// host model that drives the fast parallel load pins
`timescale 1ns/100ps
`default_nettype none
module fpl_host (
  output logic config_request_n,
  output logic config_clock,
  output logic [31:0] config_data
);
  localparam int HALF = 80;
  initial begin
    config_request_n = 1'b1;
    config_clock = 1'b0;
    config_data = 32'h0;
  end
  // request low long enough to pass the pin synchronizer
  task automatic restart();
    config_request_n = 1'b0;
    #(3 * HALF);
    config_request_n = 1'b1;
  endtask
  // one word per group of r rising edges, data set before the first one
  task automatic send_word(input logic [31:0] w, input int r);
    config_data = w;
    for (int i = 0; i < r; i++) begin
      #HALF config_clock = 1'b1;
      #HALF config_clock = 1'b0;
    end
    #(HALF / 2) config_data = ~w;
    #(HALF / 2);
  endtask
  // clock held low while paused
  task automatic pause(input int halves);
    #(halves * HALF);
  endtask
  // bare clock pulses, each ending in a falling edge
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      #HALF config_clock = 1'b1;
      #HALF config_clock = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### test/testbench.sv
// self-checking bench of the fast parallel loader
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import fpl_pkg::*;
  localparam int unsigned POR_N = 16;
  localparam int unsigned IMG_N = 4;
  logic clk, resetn, decompress_en, security_en, init_done_opt;
  logic word_ready, stall, word_valid, user_mode, load_error;
  logic config_health_n_out, config_health_n_oe_n, load_complete_out;
  logic load_complete_oe_n, init_done_out, init_done_oe_n;
  logic [31:0] word_data;
  fpl_width_e bus_width;
  wire logic config_request_n, config_clock;
  wire logic [31:0] config_data;
  wire hp = config_health_n_oe_n ? 1'b1 : config_health_n_out;
  wire lp = load_complete_oe_n ? 1'b1 : load_complete_out;
  wire ip = init_done_oe_n ? 1'b1 : init_done_out;
  logic [31:0] expq[$];
  int miscompares, comparisons;

  fpl_loader #(.POR_CNT(POR_N), .IMAGE_LEN(IMG_N)) u_fpl_loader (
    .clk, .resetn, .config_request_n, .config_clock, .config_data,
    .bus_width, .decompress_en, .security_en, .init_done_opt,
    .config_health_n_in(hp), .config_health_n_out, .config_health_n_oe_n,
    .load_complete_in(lp), .load_complete_out, .load_complete_oe_n,
    .init_done_in(ip), .init_done_out, .init_done_oe_n,
    .word_valid, .word_ready, .word_data, .user_mode, .load_error);
  fpl_host u_fpl_host (.config_request_n, .config_clock, .config_data);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return hp === 1'b1;
      1: return lp === 1'b1;
      2: return user_mode === 1'b1;
      default: return load_error === 1'b1;
    endcase
  endfunction

  // bounded wait on one pin or flag
  task automatic wait_for(input int s, input int limit);
    int n;
    n = 0;
    while (!pick(s) && n < limit) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= limit) begin
      check($sformatf("wait %0d", s), 1, 0);
      wrap_up();
    end
  endtask

  function automatic int ratio(fpl_width_e w, logic dc, logic sec);
    if (w == W8) return dc ? 2 : 1;
    if (w == W16) return dc ? 4 : (sec ? 2 : 1);
    return dc ? 8 : (sec ? 4 : 1);
  endfunction

  // word sink with random stalls
  always @(posedge clk) begin
    if (word_valid === 1'b1 && word_ready === 1'b1) begin
      if (expq.size() == 0) check("spare word", 0, 1);
      else check("word_data", expq.pop_front(), word_data);
    end
    #1 word_ready = !stall && ($urandom_range(0, 3) != 0);
  end

  initial begin
    int r;
    logic [31:0] w;
    resetn = 1'b0;
    bus_width = W32;
    {decompress_en, security_en, init_done_opt} = 3'h0;
    stall = 1'b0;
    miscompares = 0;
    comparisons = 0;
    w = $urandom(5767);
    repeat (2) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (POR_N / 2) @(posedge clk);
    check("health in por", 0, hp);
    check("done at power-up", 0, lp);
    for (int m = 0; m < 12; m++) begin
      @(posedge clk);
      #1 bus_width = fpl_width_e'(m / 4);
      decompress_en = m[1];
      security_en = m[0];
      init_done_opt = 1'($urandom_range(0, 1));
      r = ratio(bus_width, decompress_en, security_en);
      u_fpl_host.restart();
      check("health on restart", 0, hp);
      check("user_mode on restart", 0, user_mode);
      wait_for(0, 100);
      for (int i = 0; i < IMG_N; i++) begin
        w = $urandom;
        expq.push_back(bus_width == W8 ? {24'h0, w[7:0]} :
                       bus_width == W16 ? {16'h0, w[15:0]} : w);
        if (i == IMG_N - 1) check("done in load", 0, lp);
        u_fpl_host.send_word(w, r);
        if ($urandom_range(0, 3) == 0) u_fpl_host.pause(5);
      end
      wait_for(1, 200);
      check("words left", 0, 32'(expq.size()));
      check("init pin in init", {31'h0, !init_done_opt}, ip);
      u_fpl_host.pulses(1);
      repeat (6) @(posedge clk);
      #1 check("user after one fall", 0, user_mode);
      u_fpl_host.pulses(1);
      wait_for(2, 20);
      check("health in user", 1, hp);
      check("done in user", 1, lp);
      check("init pin in user", 1, ip);
      u_fpl_host.send_word($urandom, 4);
      repeat (6) @(posedge clk);
      check("user with clock", 1, user_mode);
    end
    @(posedge clk);
    #1 bus_width = W32;
    {decompress_en, security_en} = 2'h0;
    stall = 1'b1;
    u_fpl_host.restart();
    wait_for(0, 100);
    repeat (4) u_fpl_host.send_word($urandom, 1);
    wait_for(3, 50);
    check("health on overrun", 0, hp);
    u_fpl_host.restart();
    check("error after restart", 0, load_error);
    wrap_up();
  end
endmodule
`default_nettype wire
